// file: sfam_addr_dec.v
`timescale 1ns/1ps
`default_nettype none
`include "sfam_regs.vh"
module sfam_addr_dec (
  input wire [31:0] fullAddr, // Effective 32-bit address
  input wire idSpace, // Target is ID/CFI space
  output wire [1:0] space, // Selected space
  output wire [26:0] arrayAddr, // Main array offset
  output wire [7:0] sector // Sector index
);
  // Upper bits above density are dropped, so the array aliases
  assign arrayAddr = fullAddr[`SFAM_ARRAY_AW-1:0];
  assign sector = fullAddr[`SFAM_ARRAY_AW-1:`SFAM_SECTOR_LSB];
  assign space = idSpace ? `SFAM_SPACE_ID : `SFAM_SPACE_ARRAY;
endmodule // sfam_addr_dec
`default_nettype wire

// file: sfam_addr_map.v
`timescale 1ns/1ps
`default_nettype none
`include "sfam_regs.vh"
// Behaviour
// R1: Three address bytes without bank bits reach only the lowest 16 Mbytes.
// R2: Four-byte addresses decode a full 32-bit space up to 4 Gbytes.
// R3: Legacy commands keep taking three address bytes.
// R4: In 24-bit mode upper bits come from the bank register.
// R5: Extended-address bit set makes legacy commands take four bytes.
// R6: Four-byte command variants always take 32-bit addresses.
// R7: Reset clears bank register and selects 24-bit mode.
// R8: Non-array spaces still decode a full 32-bit address.
// R9: Array is 256 sectors of 512 kbytes, the erase unit.
// R10: Command 9Fh reads the separate identification space.
// R11: Identification space is read-only; writes are rejected.
// R12: Host sends register commands to both dies in parallel; the host model here drives a single sfam_addr_map.
// R13: 24-bit effective address is bank bits above the three bytes.
// R14: Bits above array density are ignored for array accesses.
module sfam_addr_map (
  input wire clock, // System clock
  input wire rstn, // Async reset, active low
  input wire softReset, // Software reset pulse
  input wire cmdValid, // Command byte strobe
  input wire [7:0] cmdCode, // Command byte
  input wire byteValid, // Address or data byte strobe
  input wire [7:0] byteIn, // Address or data byte
  input wire frameEnd, // Chip select released
  output reg addrValid_q, // Pulse: address complete
  output reg [1:0] space_q, // Target space
  output reg [31:0] fullAddr_q, // Decoded 32-bit address
  output reg [26:0] arrayAddr_q, // Main array offset
  output reg [7:0] sector_q, // Sector index
  output reg isErase_q, // Access is a sector erase
  output reg isWrite_q, // Access is a program
  output reg reject_q, // Pulse: write to read-only space
  output reg extMode_q, // Extended address mode
  output reg [7:0] bankOut_q // Bank register readback
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ADDR = 4'h2;
  localparam [3:0] ST_BANK = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [2:0] need_q;
  reg [2:0] cnt_q;
  reg lastSeen_q;
  wire [31:0] shiftBytes;
  wire [31:0] laneIn;
  wire takeCmd;
  wire takeByte;
  wire lastByte;
  genvar lane;
  reg four_q;
  reg idSp_q;
  reg wr_q;
  reg er_q;
  reg bankLoad;
  wire [7:0] bank;
  wire [31:0] effAddr;
  wire [1:0] decSpace;
  wire [26:0] decArray;
  wire [7:0] decSector;

  // Address-carrying command classification, shared by decode paths
  function isAddrCmd;
    input [7:0] c;
    begin
      isAddrCmd = (c == `SFAM_CMD_READ) || (c == `SFAM_CMD_READ4) ||
        (c == `SFAM_CMD_PROG) || (c == `SFAM_CMD_PROG4) ||
        (c == `SFAM_CMD_ERASE) || (c == `SFAM_CMD_ERASE4) ||
        (c == `SFAM_CMD_READID) || (c == `SFAM_CMD_IDWR);
    end
  endfunction

  function isFourCmd;
    input [7:0] c;
    begin
      isFourCmd = (c == `SFAM_CMD_READ4) || (c == `SFAM_CMD_PROG4) ||
        (c == `SFAM_CMD_ERASE4);
    end
  endfunction

  // ID space commands use four address bytes regardless of the bank
  function isIdCmd;
    input [7:0] c;
    begin
      isIdCmd = (c == `SFAM_CMD_READID) || (c == `SFAM_CMD_IDWR);
    end
  endfunction

  function isWriteCmd;
    input [7:0] c;
    begin
      isWriteCmd = (c == `SFAM_CMD_PROG) || (c == `SFAM_CMD_PROG4) ||
        (c == `SFAM_CMD_IDWR);
    end
  endfunction

  function isEraseCmd;
    input [7:0] c;
    begin
      isEraseCmd = (c == `SFAM_CMD_ERASE) || (c == `SFAM_CMD_ERASE4);
    end
  endfunction

  // Address width is fixed once, when the command byte is taken
  function takesFour;
    input [7:0] c;
    input ext;
    begin
      takesFour = isFourCmd(c) || ext || isIdCmd(c);
    end
  endfunction

  sfam_bank_reg uBank (
    .clock(clock),
    .rstn(rstn),
    .softReset(softReset), // R7
    .load(bankLoad),
    .loadData(byteIn),
    .bank_q(bank)
  );

  // Legacy path: bank high bits above three received bytes
  assign effAddr = four_q ? shiftBytes : // R2 R6
    {1'b0, bank[`SFAM_BANK_HI_MSB:`SFAM_BANK_HI_LSB], shiftBytes[23:0]}; // R4 R13 R1

  sfam_addr_dec uDec (
    .fullAddr(effAddr), // R8
    .idSpace(idSp_q), // R10
    .space(decSpace),
    .arrayAddr(decArray), // R14
    .sector(decSector) // R9
  );

  always @*
  begin
    state_d = state_q;
    bankLoad = 1'b0;
    case (state_q)
      ST_IDLE:
        if (cmdValid && isAddrCmd(cmdCode))
          state_d = ST_ADDR;
        else if (cmdValid && cmdCode == `SFAM_CMD_BANKWR)
          state_d = ST_BANK;
      ST_ADDR:
        if (frameEnd)
          state_d = ST_IDLE;
        else if (byteValid && cnt_q == need_q - 3'h1)
          state_d = ST_DONE;
      ST_BANK:
        if (frameEnd)
          state_d = ST_IDLE;
        else if (byteValid)
        begin
          bankLoad = 1'b1;
          state_d = ST_DONE;
        end
      ST_DONE:
        if (frameEnd)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  assign takeCmd = (state_q == ST_IDLE) && cmdValid && isAddrCmd(cmdCode);
  assign takeByte = (state_q == ST_ADDR) && byteValid && !frameEnd; // R3
  assign lastByte = (state_q == ST_ADDR) && (state_d == ST_DONE);
  assign laneIn = {shiftBytes[23:0], byteIn};

  // Lane 0 takes the new byte, every higher lane its lower neighbour
  generate
    for (lane = 0; lane < 4; lane = lane + 1)
    begin : gLane
      reg [7:0] laneByte_q;
      always @(posedge clock or negedge rstn)
      begin
        if (!rstn)
          laneByte_q <= 8'h00;
        else if (takeCmd)
          laneByte_q <= 8'h00;
        else if (takeByte)
          laneByte_q <= laneIn[8*lane+7:8*lane];
      end
      assign shiftBytes[8*lane+7:8*lane] = laneByte_q;
    end
  endgenerate

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      state_q <= ST_IDLE;
    else if (softReset)
      state_q <= ST_IDLE; // R7
    else
      state_q <= state_d;
  end

  // Command attributes held for the whole frame
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      need_q <= 3'h3;
      four_q <= 1'b0;
      idSp_q <= 1'b0;
      wr_q <= 1'b0;
      er_q <= 1'b0;
    end
    else if (takeCmd)
    begin
      four_q <= takesFour(cmdCode, bank[`SFAM_BANK_EXTADD_BIT]); // R5 R6 R8
      need_q <= takesFour(cmdCode, bank[`SFAM_BANK_EXTADD_BIT]) ? 3'h4 : 3'h3; // R3 R5 R6
      idSp_q <= isIdCmd(cmdCode); // R10
      wr_q <= isWriteCmd(cmdCode);
      er_q <= isEraseCmd(cmdCode);
    end
  end

  // One-shot flag, so the answer can never repeat while the frame stays open
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= 3'h0;
      lastSeen_q <= 1'b0;
    end
    else if (softReset)
    begin
      cnt_q <= 3'h0;
      lastSeen_q <= 1'b0;
    end
    else
    begin
      lastSeen_q <= lastByte;
      if (takeCmd)
        cnt_q <= 3'h0;
      else if (takeByte)
        cnt_q <= cnt_q + 3'h1;
    end
  end

  // Bank mirror; extended mode shows one edge after a load
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      extMode_q <= 1'b0;
      bankOut_q <= `SFAM_BANK_RESET;
    end
    else if (softReset)
    begin
      extMode_q <= 1'b0;
      bankOut_q <= `SFAM_BANK_RESET; // R7
    end
    else
    begin
      extMode_q <= bank[`SFAM_BANK_EXTADD_BIT]; // R5
      bankOut_q <= bank;
    end
  end

  // Answer one edge after the last byte so effAddr sees the full shift
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      addrValid_q <= 1'b0;
      space_q <= `SFAM_SPACE_NONE;
      fullAddr_q <= 32'h0;
      arrayAddr_q <= 27'h0;
      sector_q <= 8'h0;
      isErase_q <= 1'b0;
      isWrite_q <= 1'b0;
      reject_q <= 1'b0;
    end
    else if (softReset)
    begin
      addrValid_q <= 1'b0;
      reject_q <= 1'b0;
      space_q <= `SFAM_SPACE_NONE; // R7
    end
    else
    begin
      addrValid_q <= 1'b0;
      reject_q <= 1'b0;
      if (lastSeen_q)
      begin
        if (idSp_q && wr_q)
          reject_q <= 1'b1; // R11
        else
        begin
          addrValid_q <= 1'b1;
          space_q <= decSpace; // R10
          fullAddr_q <= effAddr; // R8
          arrayAddr_q <= decArray; // R14
          sector_q <= decSector; // R9
          isErase_q <= er_q; // R9
          isWrite_q <= wr_q;
        end
      end
    end
  end
endmodule // sfam_addr_map
`default_nettype wire

// file: sfam_addr_map_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sfam_addr_map_chk (
  input wire logic clock, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic softReset, // Software reset
  input wire logic cmdValid, // Command strobe
  input wire logic [7:0] cmdCode, // Command byte
  input wire logic byteValid, // Byte strobe
  input wire logic addrValid_q, // Answer pulse
  input wire logic [1:0] space_q, // Target space
  input wire logic [31:0] fullAddr_q, // Decoded address
  input wire logic [26:0] arrayAddr_q, // Array offset
  input wire logic [7:0] sector_q, // Sector index
  input wire logic reject_q, // Refusal pulse
  input wire logic extMode_q, // Extended mode
  input wire logic [7:0] bankOut_q // Bank readback
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  reset_default_a: assert property ($rose(rstn) |-> bankOut_q == 8'h00 && space_q == 2'h2
    && !extMode_q) else $error("bad state after reset");
  soft_reset_a: assert property (softReset |-> ##2 bankOut_q == 8'h00)
    else $error("bank not cleared by soft reset");
  legacy_three_a: assert property (cmdValid && cmdCode == 8'h03 && !extMode_q
    ##1 byteValid [*3] |-> ##2 addrValid_q) else $error("legacy read not taken");
  ext_mode_a: assert property (cmdValid && cmdCode == 8'h03 && extMode_q
    ##1 byteValid [*3] |-> ##2 !addrValid_q) else $error("ext mode took three bytes");
  four_byte_a: assert property (cmdValid && cmdCode == 8'h13
    ##1 byteValid [*3] |-> ##2 !addrValid_q) else $error("four byte read took three");
  id_read_a: assert property (cmdValid && cmdCode == 8'h9f ##1 byteValid [*4]
    |-> ##2 addrValid_q && space_q == 2'h1) else $error("id read not in id space");
  id_write_a: assert property (cmdValid && cmdCode == 8'h9e ##1 byteValid [*4]
    |-> ##2 reject_q && !addrValid_q) else $error("id write not refused");
  answer_excl_a: assert property (!(addrValid_q && reject_q))
    else $error("answer and refusal together");
  answer_pulse_a: assert property ((addrValid_q || reject_q)
    |=> !(addrValid_q || reject_q)) else $error("answer longer than one cycle");
  array_map_a: assert property (addrValid_q |-> arrayAddr_q == fullAddr_q[26:0]
    && sector_q == fullAddr_q[26:19]) else $error("array offset or sector wrong");
endmodule // sfam_addr_map_chk
bind sfam_addr_map sfam_addr_map_chk i_sfam_addr_map_chk (.*);
`default_nettype wire

// file: sfam_addr_map_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sfam_addr_map_tb_top;
  logic clock, rstn, softReset, cmdValid, byteValid, frameEnd, addrValid_q;
  logic isErase_q, isWrite_q, reject_q, extMode_q;
  logic [7:0] cmdCode, byteIn, sector_q, bankOut_q, b;
  logic [1:0] space_q;
  logic [31:0] fullAddr_q, a;
  logic [26:0] arrayAddr_q;
  logic [15:0] lfsr;
  logic [42:0] expq[$];
  logic [7:0] ops [6] = '{8'h03, 8'h02, 8'hd8, 8'h13, 8'h12, 8'hdc};
  int mismatches, comparisons, t;
  sfam_addr_map i_sfam_addr_map (.*);
  sfam_host_model i_sfam_host_model (.*);
  initial
  begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  function logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task rnd;
    lfsr = nx(lfsr);
    a[31:16] = lfsr;
    lfsr = nx(lfsr);
    a[15:0] = lfsr;
  endtask
  task chk(input logic [42:0] s, input logic [42:0] e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task rd(input logic [7:0] c, input int n, input logic [1:0] s, input logic [31:0] f);
    expq.push_back(c == 8'h9e ? {1'b1, 42'h0} : {1'b0, s, f, f[26:19]});
    if (c != 8'h9e)
      expq.push_back({14'h0, f[26:0], (c == 8'hd8 || c == 8'hdc),
        (c == 8'h02 || c == 8'h12)});
    i_sfam_host_model.frame(c, n, a);
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Sampled mid-cycle, where the one-cycle answer pulse stands settled
  always @(negedge clock)
    if (addrValid_q === 1'b1 || reject_q === 1'b1)
    begin
      if (expq.size() == 0)
        chk(43'h0, 43'h1);
      else
        chk(reject_q ? {1'b1, 42'h0} : {1'b0, space_q, fullAddr_q, sector_q},
          expq.pop_front());
      if (addrValid_q === 1'b1)
        chk({14'h0, arrayAddr_q, isErase_q, isWrite_q},
          expq.size() > 0 ? expq.pop_front() : 43'h1);
    end
  initial
  begin
    repeat (5000) @(posedge clock);
    mismatches++;
    report_and_stop;
  end
  initial
  begin
    {rstn, softReset} = 2'b00;
    lfsr = 16'h0037;
    a = 32'h0;
    repeat (12) @(posedge clock);
    @(negedge clock);
    rstn = 1;
    chk({35'h0, bankOut_q}, 43'h0);
    for (t = 0; t < 6; t++)
    begin
      rnd;
      rd(ops[t], t < 3 ? 3 : 4, 2'h0, t < 3 ? {8'h00, a[23:0]} : a);
    end
    $display("test plain done");
    rnd;
    b = {1'b0, a[30:24]};
    i_sfam_host_model.frame(8'h17, 1, {24'h0, b});
    chk({35'h0, bankOut_q}, {35'h0, b});
    rd(8'h03, 3, 2'h0, {1'b0, b[6:0], a[23:0]});
    i_sfam_host_model.frame(8'h17, 1, 32'h80);
    chk({42'h0, extMode_q}, 43'h1);
    rd(8'h03, 4, 2'h0, a);
    rd(8'h9f, 4, 2'h1, a);
    rd(8'h9e, 4, 2'h0, a);
    $display("test bank done");
    @(negedge clock);
    softReset = 1;
    @(negedge clock);
    softReset = 0;
    repeat (3) @(negedge clock);
    chk({34'h0, extMode_q, bankOut_q}, 43'h0);
    rd(8'h03, 3, 2'h0, {8'h00, a[23:0]});
    $display("test reset done");
    for (t = 0; t < 50 && expq.size() > 0; t++)
      @(posedge clock);
    if (expq.size() > 0)
      mismatches++;
    report_and_stop;
  end
endmodule // sfam_addr_map_tb_top
`default_nettype wire

// file: sfam_bank_reg.v
`timescale 1ns/1ps
`default_nettype none
`include "sfam_regs.vh"
module sfam_bank_reg (
  input wire clock, // System clock
  input wire rstn, // Async reset, active low
  input wire softReset, // Software reset pulse
  input wire load, // Load strobe
  input wire [7:0] loadData, // New bank value
  output reg [7:0] bank_q // Bank register
);
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      bank_q <= `SFAM_BANK_RESET;
    else if (softReset)
      bank_q <= `SFAM_BANK_RESET;
    else if (load)
      bank_q <= loadData;
  end
endmodule // sfam_bank_reg
`default_nettype wire

// file: sfam_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfam_host_model (
  input wire logic clock, // Clock
  output logic cmdValid, // Command strobe
  output logic [7:0] cmdCode, // Command byte
  output logic byteValid, // Byte strobe
  output logic [7:0] byteIn, // Address or data byte
  output logic frameEnd // Frame close
);
  initial
  begin
    {cmdValid, cmdCode, byteValid, byteIn, frameEnd} = '0;
  end
  // One command per frame, always closed by a frameEnd pulse
  task frame(input logic [7:0] c, input int n, input logic [31:0] a);
    int i;
    @(negedge clock);
    cmdValid = 1;
    cmdCode = c;
    for (i = n - 1; i >= 0; i--)
    begin
      @(negedge clock);
      cmdValid = 0;
      byteValid = 1;
      byteIn = a[8*i +: 8];
    end
    @(negedge clock);
    byteValid = 0;
    // Stale byte must not look valid
    byteIn = ~byteIn;
    repeat (3) @(negedge clock);
    frameEnd = 1;
    @(negedge clock);
    frameEnd = 0;
  endtask
endmodule // sfam_host_model
`default_nettype wire

// file: sfam_regs.vh
`ifndef SFAM_REGS_VH
`define SFAM_REGS_VH
// Command codes
`define SFAM_CMD_READ 8'h03
`define SFAM_CMD_READ4 8'h13
`define SFAM_CMD_PROG 8'h02
`define SFAM_CMD_PROG4 8'h12
`define SFAM_CMD_ERASE 8'hd8
`define SFAM_CMD_ERASE4 8'hdc
`define SFAM_CMD_BANKWR 8'h17
`define SFAM_CMD_BANKRD 8'h16
`define SFAM_CMD_READID 8'h9f
`define SFAM_CMD_IDWR 8'h9e
// Bank register fields
`define SFAM_BANK_RESET 8'h00
`define SFAM_BANK_EXTADD_BIT 7
`define SFAM_BANK_HI_MSB 6
`define SFAM_BANK_HI_LSB 0
// Array geometry: 128 Mbytes, 256 sectors of 512 kbytes
`define SFAM_ARRAY_AW 27
`define SFAM_SECTOR_LSB 19
`define SFAM_SECTOR_W 8
`define SFAM_LEGACY_AW 24
// Space selector codes
`define SFAM_SPACE_ARRAY 2'h0
`define SFAM_SPACE_ID 2'h1
`define SFAM_SPACE_NONE 2'h2
`endif
